// File: sic_pkg.sv
// Constants and types for the six-level interrupt controller
package sic_pkg;
	localparam int unsigned NUM_LEVELS = 6;
	// Register file addresses of the three control registers
	localparam logic [7:0] ADDR_PRIORITY = 8'hF9;
	localparam logic [7:0] ADDR_REQUEST = 8'hFA;
	localparam logic [7:0] ADDR_MASK = 8'hFB;
	// Reset values
	localparam logic [7:0] PRIORITY_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [5:0] REQUEST_RESET = 6'h00;
	// Field positions
	localparam int unsigned MASK_MASTER_BIT = 7;
	localparam int unsigned PRI_C_BIT = 1;
	localparam int unsigned PRI_B_BIT = 2;
	localparam int unsigned PRI_A_BIT = 5;
	localparam int unsigned PRI_CODE_HI_BIT = 4;
	localparam int unsigned PRI_CODE_MID_BIT = 3;
	localparam int unsigned PRI_CODE_LO_BIT = 0;
	// Level numbers
	localparam logic [2:0] LVL_0 = 3'h0;
	localparam logic [2:0] LVL_1 = 3'h1;
	localparam logic [2:0] LVL_2 = 3'h2;
	localparam logic [2:0] LVL_3 = 3'h3;
	localparam logic [2:0] LVL_4 = 3'h4;
	localparam logic [2:0] LVL_5 = 3'h5;
	// Group order codes
	localparam logic [2:0] ORD_CAB = 3'h1;
	localparam logic [2:0] ORD_ABC = 3'h2;
	localparam logic [2:0] ORD_ACB = 3'h3;
	localparam logic [2:0] ORD_BCA = 3'h4;
	localparam logic [2:0] ORD_CBA = 3'h5;
	localparam logic [2:0] ORD_BAC = 3'h6;
	// Interrupt cycle steps, Gray coded along the sequence
	typedef enum logic [2:0] {
		SIC_IDLE = 3'h0,
		SIC_PUSH_PCL = 3'h1,
		SIC_PUSH_PCH = 3'h3,
		SIC_PUSH_FLAGS = 3'h2,
		SIC_FETCH_VH = 3'h6,
		SIC_FETCH_VL = 3'h7,
		SIC_BRANCH = 3'h5
	} sic_step_t;
endpackage

// File: sic_edge_sync.sv
// Falling-edge capture and two-stage synchroniser for one port line
`timescale 1ns/1ps
module sic_edge_sync (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_line,
	output logic o_req
);
	logic prev_reg, prev_next;
	logic cap_reg, cap_next;
	logic s1_reg, s1_next;
	logic s2_reg, s2_next;
	logic done_reg, done_next;
	logic req_reg, req_next;

	always_comb begin
		prev_next = i_line;
		// Capture holds until the request has passed both stages
		cap_next = (cap_reg & ~s2_reg) | (prev_reg & ~i_line);
		s1_next = cap_reg;
		s2_next = s1_reg;
		// Pulse taken from the settled stage only, never from the first stage
		done_next = s2_reg;
		req_next = s2_reg & ~done_reg;
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			prev_reg <= 1'b1;
			cap_reg <= 1'b0;
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			done_reg <= 1'b0;
			req_reg <= 1'b0;
		end else begin
			prev_reg <= prev_next;
			cap_reg <= cap_next;
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			done_reg <= done_next;
			req_reg <= req_next;
		end
	end

	assign o_req = req_reg;

	property p_delay;
		@(posedge i_mclk) disable iff (i_rst) $rose(cap_reg) |-> ##3 req_reg;
	endproperty
	a_delay: assert property (p_delay) else $error("port request delay wrong");
endmodule

// File: sic_top.sv
// Six-level interrupt request capture, masking and priority logic
`timescale 1ns/1ps
module sic_top (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic [3:0] i_port3_line,
	input wire logic i_serial_rx_en,
	input wire logic i_rx_byte_done,
	input wire logic i_serial_tx_en,
	input wire logic i_tx_empty,
	input wire logic i_timer0_en,
	input wire logic i_timer0_eoc,
	input wire logic i_timer1_eoc,
	input wire logic i_sample,
	input wire logic i_int_ack,
	input wire logic i_ei,
	input wire logic i_di,
	input wire logic i_interrupt_return_instruction,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	output logic o_int_req,
	output logic [2:0] o_int_level,
	output logic [7:0] o_vec_addr,
	output sic_pkg::sic_step_t o_step
);
	logic [3:0] ext_pulse;
	logic [5:0] src;
	logic [5:0] src_prev_reg, src_prev_next;
	logic [5:0] lat_reg, lat_next;
	logic [5:0] flag_reg, flag_next;
	logic [7:0] mask_reg, mask_next;
	logic [7:0] pri_reg, pri_next;
	logic ei_seen_reg, ei_seen_next;
	logic [7:0] rdata_reg, rdata_next;
	logic int_req_reg, int_req_next;
	logic [2:0] level_reg, level_next;
	logic [7:0] vec_reg, vec_next;
	sic_pkg::sic_step_t step_reg, step_next;
	logic [5:0] eligible;
	logic [2:0] sel_lvl;
	logic int_any;
	logic ack_take;
	logic [3:0] grp_a, grp_b, grp_c;
	logic [2:0] order;

	// Port line order 2,3,1,0 feeds levels 0..3; line 0 reaches level 3 only while i_serial_rx_en is low
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_ext
			sic_edge_sync u_sync (
				.i_mclk(i_mclk),
				.i_rst(i_rst),
				.i_line(i_port3_line[g]),
				.o_req(ext_pulse[g])
			);
		end
	endgenerate

	// Pick one member of a pair; returns {valid, level}
	function automatic logic [3:0] pair_pick(input logic [5:0] el, input logic [2:0] first,
		input logic [2:0] second);
		logic [3:0] r;
		r = 4'h0;
		if (el[first])
			r = {1'b1, first};
		else if (el[second])
			r = {1'b1, second};
		return r;
	endfunction

	always_comb begin
		src[0] = ext_pulse[2];
		src[1] = ext_pulse[3];
		src[2] = ext_pulse[1];
		src[3] = i_serial_rx_en ? i_rx_byte_done : ext_pulse[0];
		src[4] = (i_serial_tx_en & i_tx_empty) | (i_timer0_en & i_timer0_eoc);
		src[5] = i_timer1_eoc;
	end

	// Priority resolution
	always_comb begin
		eligible = flag_reg & mask_reg[5:0] & {6{mask_reg[sic_pkg::MASK_MASTER_BIT]}};
		grp_a = pri_reg[sic_pkg::PRI_A_BIT] ?
			pair_pick(eligible, sic_pkg::LVL_3, sic_pkg::LVL_5) :
			pair_pick(eligible, sic_pkg::LVL_5, sic_pkg::LVL_3);
		grp_b = pri_reg[sic_pkg::PRI_B_BIT] ?
			pair_pick(eligible, sic_pkg::LVL_0, sic_pkg::LVL_2) :
			pair_pick(eligible, sic_pkg::LVL_2, sic_pkg::LVL_0);
		grp_c = pri_reg[sic_pkg::PRI_C_BIT] ?
			pair_pick(eligible, sic_pkg::LVL_4, sic_pkg::LVL_1) :
			pair_pick(eligible, sic_pkg::LVL_1, sic_pkg::LVL_4);
		order = {pri_reg[sic_pkg::PRI_CODE_HI_BIT], pri_reg[sic_pkg::PRI_CODE_MID_BIT],
			pri_reg[sic_pkg::PRI_CODE_LO_BIT]};
		sel_lvl = 3'h0;
		int_any = grp_a[3] | grp_b[3] | grp_c[3];
		case (order)
			sic_pkg::ORD_CAB: sel_lvl = grp_c[3] ? grp_c[2:0] : (grp_a[3] ? grp_a[2:0] : grp_b[2:0]);
			sic_pkg::ORD_ACB: sel_lvl = grp_a[3] ? grp_a[2:0] : (grp_c[3] ? grp_c[2:0] : grp_b[2:0]);
			sic_pkg::ORD_BCA: sel_lvl = grp_b[3] ? grp_b[2:0] : (grp_c[3] ? grp_c[2:0] : grp_a[2:0]);
			sic_pkg::ORD_CBA: sel_lvl = grp_c[3] ? grp_c[2:0] : (grp_b[3] ? grp_b[2:0] : grp_a[2:0]);
			sic_pkg::ORD_BAC: sel_lvl = grp_b[3] ? grp_b[2:0] : (grp_a[3] ? grp_a[2:0] : grp_c[2:0]);
			// ABC and the two unused codes share one fixed order
			default: sel_lvl = grp_a[3] ? grp_a[2:0] : (grp_b[3] ? grp_b[2:0] : grp_c[2:0]);
		endcase
	end

	// Request latches, flags and control registers
	always_comb begin
		ack_take = i_int_ack & int_any & (step_reg == sic_pkg::SIC_IDLE);
		src_prev_next = src;
		// New edge wins over the sample clear
		lat_next = (lat_reg & ~{6{i_sample}}) | (src & ~src_prev_reg);
		ei_seen_next = ei_seen_reg | i_ei;
		flag_next = flag_reg;
		if (i_reg_wr && i_reg_addr == sic_pkg::ADDR_REQUEST)
			flag_next = i_reg_wdata[5:0];
		if (ack_take)
			flag_next = flag_next & ~(6'h01 << sic_pkg::NUM_LEVELS'(sel_lvl));
		if (i_sample)
			flag_next = flag_next | lat_reg;
		if (!ei_seen_reg)
			flag_next = sic_pkg::REQUEST_RESET;
		mask_next = mask_reg;
		if (i_reg_wr && i_reg_addr == sic_pkg::ADDR_MASK)
			mask_next = {i_reg_wdata[7], 1'b0, i_reg_wdata[5:0]};
		if (i_ei || i_interrupt_return_instruction)
			mask_next[sic_pkg::MASK_MASTER_BIT] = 1'b1;
		if (i_di || ack_take)
			mask_next[sic_pkg::MASK_MASTER_BIT] = 1'b0;
		pri_next = pri_reg;
		if (i_reg_wr && i_reg_addr == sic_pkg::ADDR_PRIORITY)
			pri_next = {2'h0, i_reg_wdata[5:0]};
		rdata_next = rdata_reg;
		if (i_reg_rd) begin
			// Priority register is write-only and reads as zero
			case (i_reg_addr)
				sic_pkg::ADDR_REQUEST: rdata_next = {2'h0, flag_reg};
				sic_pkg::ADDR_MASK: rdata_next = {mask_reg[7], 1'b0, mask_reg[5:0]};
				default: rdata_next = 8'h00;
			endcase
		end
		int_req_next = int_any;
		level_next = sel_lvl;
	end

	// Interrupt cycle sequence
	always_comb begin
		step_next = step_reg;
		vec_next = vec_reg;
		unique case (step_reg)
			sic_pkg::SIC_IDLE: begin
				if (ack_take) begin
					step_next = sic_pkg::SIC_PUSH_PCL;
					vec_next = {4'h0, sel_lvl, 1'b0};
				end
			end
			sic_pkg::SIC_PUSH_PCL: step_next = sic_pkg::SIC_PUSH_PCH;
			sic_pkg::SIC_PUSH_PCH: step_next = sic_pkg::SIC_PUSH_FLAGS;
			sic_pkg::SIC_PUSH_FLAGS: step_next = sic_pkg::SIC_FETCH_VH;
			sic_pkg::SIC_FETCH_VH: begin
				step_next = sic_pkg::SIC_FETCH_VL;
				vec_next = vec_reg | 8'h01;
			end
			sic_pkg::SIC_FETCH_VL: step_next = sic_pkg::SIC_BRANCH;
			sic_pkg::SIC_BRANCH: step_next = sic_pkg::SIC_IDLE;
			default: step_next = sic_pkg::SIC_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			src_prev_reg <= 6'h00;
			lat_reg <= 6'h00;
			flag_reg <= sic_pkg::REQUEST_RESET;
			mask_reg <= sic_pkg::MASK_RESET;
			pri_reg <= sic_pkg::PRIORITY_RESET;
			ei_seen_reg <= 1'b0;
			rdata_reg <= 8'h00;
			int_req_reg <= 1'b0;
			level_reg <= 3'h0;
			vec_reg <= 8'h00;
			step_reg <= sic_pkg::SIC_IDLE;
		end else begin
			src_prev_reg <= src_prev_next;
			lat_reg <= lat_next;
			flag_reg <= flag_next;
			mask_reg <= mask_next;
			pri_reg <= pri_next;
			ei_seen_reg <= ei_seen_next;
			rdata_reg <= rdata_next;
			int_req_reg <= int_req_next;
			level_reg <= level_next;
			vec_reg <= vec_next;
			step_reg <= step_next;
		end
	end

	assign o_reg_rdata = rdata_reg;
	assign o_int_req = int_req_reg;
	assign o_int_level = level_reg;
	assign o_vec_addr = vec_reg;
	assign o_step = step_reg;

	property p_hold;
		@(posedge i_mclk) disable iff (i_rst) !ei_seen_reg |-> flag_reg == 6'h00;
	endproperty
	a_hold: assert property (p_hold) else $error("request flags set before enable");

	property p_lat;
		@(posedge i_mclk) disable iff (i_rst)
			!i_sample |=> (lat_reg & $past(lat_reg)) == $past(lat_reg);
	endproperty
	a_lat: assert property (p_lat) else $error("latch dropped before sample");

	property p_xfer;
		@(posedge i_mclk) disable iff (i_rst)
			i_sample && ei_seen_reg |=> (flag_reg & $past(lat_reg)) == $past(lat_reg);
	endproperty
	a_xfer: assert property (p_xfer) else $error("sample did not move latch");

	property p_ack;
		@(posedge i_mclk) disable iff (i_rst)
			ack_take && !i_reg_wr && !i_sample
			|=> flag_reg == ($past(flag_reg) & ~(6'h01 << $past(sel_lvl)));
	endproperty
	a_ack: assert property (p_ack) else $error("wrong flag cleared on ack");

	property p_master;
		@(posedge i_mclk) disable iff (i_rst)
			ack_take && !i_ei && !i_interrupt_return_instruction |=> !mask_reg[7] ##1 !o_int_req;
	endproperty
	a_master: assert property (p_master) else $error("master enable kept on ack");

	property p_vec;
		@(posedge i_mclk) disable iff (i_rst)
			ack_take |=> o_vec_addr == {4'h0, $past(sel_lvl), 1'b0} ##4 o_vec_addr[0];
	endproperty
	a_vec: assert property (p_vec) else $error("vector address wrong");

	property p_seq;
		@(posedge i_mclk) disable iff (i_rst)
			step_reg == sic_pkg::SIC_PUSH_PCL |=> step_reg == sic_pkg::SIC_PUSH_PCH
			##1 step_reg == sic_pkg::SIC_PUSH_FLAGS ##1 step_reg == sic_pkg::SIC_FETCH_VH
			##1 step_reg == sic_pkg::SIC_FETCH_VL ##1 step_reg == sic_pkg::SIC_BRANCH
			##1 step_reg == sic_pkg::SIC_IDLE;
	endproperty
	a_seq: assert property (p_seq) else $error("interrupt cycle order wrong");

	property p_pair;
		@(posedge i_mclk) disable iff (i_rst)
			eligible == 6'h28 |-> sel_lvl == (pri_reg[5] ? 3'h3 : 3'h5);
	endproperty
	a_pair: assert property (p_pair) else $error("pair A order wrong");

	property p_order;
		@(posedge i_mclk) disable iff (i_rst)
			eligible == 6'h09 && {pri_reg[4], pri_reg[3], pri_reg[0]} == 3'h2 |-> sel_lvl == 3'h3;
	endproperty
	a_order: assert property (p_order) else $error("group order wrong");

	property p_pick;
		@(posedge i_mclk) disable iff (i_rst) int_any |-> eligible[sel_lvl];
	endproperty
	a_pick: assert property (p_pick) else $error("selected level not eligible");
endmodule

// File: sic_core_model.sv
// Processor core stand-in: fetch sample pulses and interrupt acknowledge
`timescale 1ns/1ps
module sic_core_model (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic [3:0] i_gap,
	input wire logic i_ack_en,
	input wire logic i_int_req,
	input wire logic [2:0] i_step,
	output logic o_sample,
	output logic o_int_ack
);
	int cnt;
	initial begin
		o_sample = 1'b0;
		o_int_ack = 1'b0;
		cnt = 0;
		forever begin
			@(negedge i_mclk);
			// One pulse in the last cycle before each fetch, spacing from i_gap
			o_sample = !i_rst && (cnt >= int'(i_gap));
			cnt = o_sample ? 0 : cnt + 1;
			// Take an interrupt cycle only from idle with a live request
			o_int_ack = i_ack_en && i_int_req && i_step == sic_pkg::SIC_IDLE && !o_int_ack;
		end
	end
endmodule

// File: tb_six_level_interrupt_controller.sv
// Self-checking bench for the six-level interrupt controller
`timescale 1ns/1ps
module tb_six_level_interrupt_controller;
	typedef struct {int k; int due; logic [7:0] v;} sic_note_t;
	localparam logic [5:0] ORD [8] = '{6'h06, 6'h21, 6'h06, 6'h09, 6'h18, 6'h24, 6'h12, 6'h06};
	localparam logic [2:0] STEPS [6] = '{3'h3, 3'h2, 3'h6, 3'h7, 3'h5, 3'h0};
	logic i_mclk, i_rst, i_serial_rx_en, i_rx_byte_done, i_serial_tx_en, i_tx_empty;
	logic i_timer0_en, i_timer0_eoc, i_timer1_eoc, i_ei, i_di, i_interrupt_return_instruction, i_reg_wr, i_reg_rd;
	logic i_sample, i_int_ack, o_int_req, ack_en;
	logic [3:0] i_port3_line, gap;
	logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, o_vec_addr, pri, msk;
	logic [5:0] req;
	logic [2:0] o_int_level;
	sic_pkg::sic_step_t o_step;
	int cyc, mismatches, checked;
	sic_note_t q[$];
	sic_note_t n;
	sic_top uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_port3_line(i_port3_line),
		.i_serial_rx_en(i_serial_rx_en), .i_rx_byte_done(i_rx_byte_done),
		.i_serial_tx_en(i_serial_tx_en), .i_tx_empty(i_tx_empty), .i_timer0_en(i_timer0_en),
		.i_timer0_eoc(i_timer0_eoc), .i_timer1_eoc(i_timer1_eoc), .i_sample(i_sample),
		.i_int_ack(i_int_ack), .i_ei(i_ei), .i_di(i_di), .i_interrupt_return_instruction(i_interrupt_return_instruction), .i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.o_reg_rdata(o_reg_rdata), .o_int_req(o_int_req), .o_int_level(o_int_level),
		.o_vec_addr(o_vec_addr), .o_step(o_step));
	sic_core_model core (.i_mclk(i_mclk), .i_rst(i_rst), .i_gap(gap), .i_ack_en(ack_en),
		.i_int_req(o_int_req), .i_step(o_step), .o_sample(i_sample), .o_int_ack(i_int_ack));
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge i_mclk) begin
		cyc = cyc + 1;
		if (cyc > 20000) begin
			mismatches = mismatches + 1;
			end_of_test();
		end
	end
	function automatic logic [7:0] obs(input int k);
		case (k)
			0: return o_reg_rdata;
			1: return {5'h00, o_int_level};
			2: return {7'h00, o_int_req};
			3: return {5'h00, o_step};
			default: return o_vec_addr;
		endcase
	endfunction
	// Winner under a priority value among eligible levels, 7 when none
	function automatic logic [2:0] win(input logic [7:0] p, input logic [5:0] e);
		logic [5:0] m [3];
		logic [5:0] o;
		logic [1:0] g;
		m[0] = p[5] ? 6'h1D : 6'h2B;
		m[1] = p[2] ? 6'h02 : 6'h10;
		m[2] = p[1] ? 6'h21 : 6'h0C;
		o = ORD[{p[4], p[3], p[0]}];
		win = 3'h7;
		for (int i = 2; i >= 0; i--) begin
			g = o[2 * i +: 2];
			for (int j = 1; j >= 0; j--)
				if (win == 3'h7 && e[m[g][3 * j +: 3]]) win = m[g][3 * j +: 3];
		end
	endfunction
	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		checked = checked + 1;
		if (g !== e) begin
			mismatches = mismatches + 1;
			$display("FAIL t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// Result watcher: takes the oldest note once its edge has passed
	initial forever begin
		@(posedge i_mclk);
		#1;
		while (q.size() > 0 && q[0].due <= cyc) begin
			n = q.pop_front();
			chk(n.v, obs(n.k));
		end
	end
	task automatic note(input int k, input logic [7:0] v, input int d);
		q.push_back('{k, cyc + d, v});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_mclk);
		i_reg_wr = 1'b1;
		i_reg_addr = a;
		i_reg_wdata = d;
		@(negedge i_mclk);
		i_reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge i_mclk);
		i_reg_rd = 1'b1;
		i_reg_addr = a;
		note(0, e, 1);
		@(negedge i_mclk);
		i_reg_rd = 1'b0;
	endtask
	task automatic ins(input int w);
		@(negedge i_mclk);
		i_ei = (w == 0);
		i_di = (w == 1);
		i_interrupt_return_instruction = (w == 2);
		@(negedge i_mclk);
		{i_ei, i_di, i_interrupt_return_instruction} = 3'h0;
	endtask
	task automatic ev(input logic [3:0] f, input logic [3:0] p, input logic [2:0] en,
		input logic [5:0] e);
		gap = 4'($urandom);
		@(negedge i_mclk);
		{i_timer0_en, i_serial_tx_en, i_serial_rx_en} = en;
		@(negedge i_mclk);
		i_port3_line = ~f;
		{i_timer1_eoc, i_timer0_eoc, i_tx_empty, i_rx_byte_done} = p;
		@(negedge i_mclk);
		i_port3_line = 4'hF;
		{i_timer1_eoc, i_timer0_eoc, i_tx_empty, i_rx_byte_done} = 4'h0;
		repeat (24) @(negedge i_mclk);
		rd(sic_pkg::ADDR_REQUEST, {2'h0, e});
		wr(sic_pkg::ADDR_REQUEST, 8'h00);
	endtask
	initial begin
		{i_serial_rx_en, i_rx_byte_done, i_serial_tx_en, i_tx_empty, i_timer0_en} = 5'h00;
		{i_timer0_eoc, i_timer1_eoc, i_ei, i_di, i_interrupt_return_instruction, i_reg_wr, i_reg_rd, ack_en} = 8'h00;
		{i_port3_line, gap, i_reg_addr, i_reg_wdata} = {4'hF, 4'h7, 16'h0000};
		cyc = 0;
		mismatches = 0;
		checked = 0;
		void'($urandom(32'hDA2D));
		i_rst = 1'b1;
		repeat (8) @(negedge i_mclk);
		i_rst = 1'b0;
		wr(sic_pkg::ADDR_REQUEST, 8'h3F);
		rd(sic_pkg::ADDR_REQUEST, 8'h00);
		rd(sic_pkg::ADDR_MASK, 8'h00);
		rd(8'h00, 8'h00);
		$display("test reset done");
		ins(0);
		ev(4'h4, 4'h0, 3'h0, 6'h01);
		ev(4'h8, 4'h0, 3'h0, 6'h02);
		ev(4'h2, 4'h0, 3'h0, 6'h04);
		ev(4'h1, 4'h0, 3'h0, 6'h08);
		ev(4'h1, 4'h0, 3'h1, 6'h00);
		ev(4'h0, 4'h1, 3'h1, 6'h08);
		ev(4'h0, 4'h1, 3'h0, 6'h00);
		ev(4'h0, 4'h2, 3'h2, 6'h10);
		ev(4'h0, 4'h4, 3'h4, 6'h10);
		ev(4'h0, 4'h8, 3'h0, 6'h20);
		ev(4'hC, 4'h8, 3'h0, 6'h23);
		$display("test sources done");
		for (int t = 0; t < 40; t++) begin
			pri = 8'($urandom);
			if (t < 8) {pri[4], pri[3], pri[0]} = 3'(t);
			msk = {2'h2, 6'($urandom)};
			req = 6'($urandom);
			// Last rounds pin pair and group orders that random values may miss
			if (t >= 37) begin
				pri = (t == 38) ? 8'h28 : 8'h08;
				req = (t == 39) ? 6'h09 : 6'h28;
				msk[5:0] = req;
			end
			// Software order: priority, then mask, then request
			wr(sic_pkg::ADDR_PRIORITY, pri);
			wr(sic_pkg::ADDR_MASK, msk);
			wr(sic_pkg::ADDR_REQUEST, {2'h0, req});
			repeat (2) @(negedge i_mclk);
			note(2, {7'h00, (req & msk[5:0]) != 6'h00}, 1);
			if ((req & msk[5:0]) != 6'h00) note(1, {5'h0, win(pri, req & msk[5:0])}, 1);
			rd(sic_pkg::ADDR_PRIORITY, 8'h00);
			rd(sic_pkg::ADDR_MASK, msk);
		end
		$display("test priority done");
		wr(sic_pkg::ADDR_PRIORITY, 8'h08);
		wr(sic_pkg::ADDR_MASK, 8'hFF);
		wr(sic_pkg::ADDR_REQUEST, 8'h3F);
		rd(sic_pkg::ADDR_MASK, 8'hBF);
		note(1, 8'h05, 1);
		ack_en = 1'b1;
		for (int w = 0; w < 50 && o_step !== sic_pkg::SIC_PUSH_PCL; w++) @(negedge i_mclk);
		ack_en = 1'b0;
		for (int s = 0; s < 6; s++) begin
			note(3, {5'h00, STEPS[s]}, s + 1);
			if (s < 5) note(4, {7'h05, s >= 3}, s + 1);
		end
		repeat (7) @(negedge i_mclk);
		rd(sic_pkg::ADDR_REQUEST, 8'h1F);
		rd(sic_pkg::ADDR_MASK, 8'h3F);
		note(2, 8'h00, 1);
		ins(2);
		repeat (2) @(negedge i_mclk);
		note(1, 8'h03, 1);
		rd(sic_pkg::ADDR_MASK, 8'hBF);
		ins(1);
		repeat (2) @(negedge i_mclk);
		note(2, 8'h00, 1);
		repeat (3) @(negedge i_mclk);
		$display("test interrupt cycle done");
		end_of_test();
	end
endmodule
